// ---- logic/rpsd_pkg.sv ----
`default_nettype none
package rpsd_pkg;
  // ==========================================================
  // widths and counts
  localparam int LEN_W = 16;
  localparam int N_POOLS = 4;
  localparam int POOL_IDX_W = 2;
  localparam int N_EXT = 4;
  localparam int FIRST_EXT_CHAN = 3;
  localparam int CHAN_W = 3;
  localparam int XFER_BYTES = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] GAP_CYCLES = 2'h2;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // ==========================================================
  // register byte offsets
  localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFF_POOL0 = 8'h04;
  localparam logic [APB_AW-1:0] OFF_POOL_STEP = 8'h04;
  localparam logic [APB_AW-1:0] OFF_STATUS = 8'h14;
  localparam logic [APB_AW-1:0] OFF_XCOUNT = 8'h18;
  localparam logic [APB_AW-1:0] OFF_XLEN = 8'h1C;

  // ==========================================================
  // field positions
  localparam int POOL_AVAIL_BIT = 31;
  localparam int STAT_NORMAL_COMPLETION_PENDING_BIT = 31;
  localparam int STAT_BUFFER_NOT_READY_PENDING_BIT = 29;
  localparam int STAT_POOL_LSB = 16;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_PEND_BIT = 0;

  // ==========================================================
  // control register, low bits of the CTRL word
  typedef struct packed {
    logic eth_receive_dma_enable;
    logic dir_to_mem;
    logic last_flag;
    logic req_src_ext;
    logic done_out;
    logic mem_to_mem;
    logic [N_EXT-1:0] ext_en;
    logic [N_POOLS-1:0] pool_en;
  } rpsd_ctrl_s;
  localparam int CTRL_W = $bits(rpsd_ctrl_s);
  localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;

  typedef struct packed {
    logic avail;
    logic [LEN_W-1:0] size;
  } rpsd_pool_s;
  localparam logic [LEN_W:0] POOL_RST = 17'h00000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_XFER = 5'b00010,
    ST_WR = 5'b00100,
    ST_GAP = 5'b01000,
    ST_CLOSE = 5'b10000
  } rpsd_state_e;
endpackage
`default_nettype wire

// ---- logic/rpsd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module rpsd_sync import rpsd_pkg::*; #(
  parameter int W = 1,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // ==========================================================
  // two flops; the first is read only by the second
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  if (W < 1) begin : g_chk
    $error("rpsd_sync width must be at least one");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= {W{RST_VAL}};
      sync_q <= {W{RST_VAL}};
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

// ---- logic/rpsd_pool_pick.sv ----
`timescale 1ns/1ps
`default_nettype none
module rpsd_pool_pick import rpsd_pkg::*; #(
  parameter int N = N_POOLS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] en_i,
  input wire logic [N-1:0] avail_i,
  input wire logic [N*LEN_W-1:0] size_i,
  input wire logic [LEN_W-1:0] len_i,
  output logic hit_o,
  output logic [POOL_IDX_W-1:0] idx_o
);
  // ==========================================================
  // ordered first-fit search
  logic [N-1:0] fit;
  logic [N-1:0] take;
  logic [N:0] stop;
  logic [POOL_IDX_W-1:0] idx_acc [N+1];

  if (N < 1 || N > (1 << POOL_IDX_W)) begin : g_chk
    $error("rpsd_pool_pick pool count out of range");
  end

  assign stop[0] = 1'b0;
  assign idx_acc[0] = '0;
  for (genvar k = 0; k < N; k++) begin : g_pool
    assign fit[k] = en_i[k] & avail_i[k] & (size_i[k*LEN_W +: LEN_W] >= len_i);
    // a disabled pool ends the walk even if a later one would fit
    assign stop[k+1] = stop[k] | ~en_i[k] | fit[k];
    assign take[k] = fit[k] & ~stop[k];
    assign idx_acc[k+1] = idx_acc[k] | (take[k] ? POOL_IDX_W'(k) : '0);
  end

  assign hit_o = |take;
  assign idx_o = idx_acc[N];

  // ==========================================================
  // checks
  property p_first_fit;
    @(posedge clk_i) disable iff (rst_i)
      hit_o |-> fit[idx_o] && ((fit & ((N'(1) << idx_o) - N'(1))) == '0);
  endproperty
  a_first_fit: assert property (p_first_fit) else $error("pick is not first fit");

  property p_first_disabled;
    @(posedge clk_i) disable iff (rst_i)
      !en_i[0] |-> !hit_o;
  endproperty
  a_first_disabled: assert property (p_first_disabled) else $error("pick past pool off");
endmodule
`default_nettype wire

// ---- logic/rpsd_top.sv ----
// Operation
// - walk pools A, B, C, D in order
// - take first available pool that fits frame
// - stop walk at a disabled pool
// - one to four pools via enable bits
// - fifo full sets buffer not ready flag
// - channels three to six use handshake
// - fly-by or memory-to-memory transfer styles
// - held or pulsed request treated alike
// - acknowledge low with memory cycle start
// - done pin direction set by config bit
// - done input closes buffer, length, completion
// - done output on last emptied buffer
// - halt while not ready, retry after clear
// - memory-to-memory acks both portions, done too
`timescale 1ns/1ps
`default_nettype none
module rpsd_top import rpsd_pkg::*; #(
  parameter int XFER_BYTES_P = XFER_BYTES
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [APB_AW-1:0] PADDR_I,
  input wire logic [APB_DW-1:0] PWDATA_I,
  output logic [APB_DW-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RX_FRAME_I,
  input wire logic [LEN_W-1:0] RX_LEN_I,
  input wire logic RX_FIFO_FULL_I,
  output logic RX_READY_O,
  output logic RX_GRANT_O,
  output logic [POOL_IDX_W-1:0] RX_POOL_O,
  input wire logic EXT_REQUEST_N_I,
  output logic EXT_ACKNOWLEDGE_N_O,
  output logic EXT_RW_N_O,
  output logic MEM_CYCLE_O,
  output logic [CHAN_W-1:0] EXT_CHAN_O,
  input wire logic EXT_DONE_N_I,
  output logic EXT_DONE_N_O,
  output logic EXT_DONE_OE_N_O,
  output logic DESC_CLOSE_O,
  output logic [LEN_W-1:0] DESC_LEN_O
);
  if (XFER_BYTES_P < 1 || XFER_BYTES_P > 8) begin : g_chk
    $error("rpsd_top bytes per transfer out of range");
  end

  // ==========================================================
  // state
  rpsd_ctrl_s ctrl_q;
  rpsd_pool_s pool_q [N_POOLS];
  logic [LEN_W-1:0] xcount_q;
  logic [LEN_W-1:0] xlen_q;
  logic [LEN_W-1:0] cnt_q;
  logic [LEN_W-1:0] rx_len_q;
  logic frame_pend_q;
  logic buffer_not_ready_pending_q;
  logic normal_completion_pending_q;
  logic grant_q;
  logic [POOL_IDX_W-1:0] pool_sel_q;
  logic [APB_DW-1:0] prdata_q;
  logic pslverr_q;
  rpsd_state_e state_q;
  rpsd_state_e state_d;
  logic [1:0] gap_q;
  logic done_in_q;
  logic ack_n_q;
  logic rw_n_q;
  logic done_n_q;
  logic close_q;

  // ==========================================================
  // pin synchronisers
  logic req_n_s;
  logic done_n_s;

  rpsd_sync #(.W(1), .RST_VAL(1'b1)) u_req_sync (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .d_i(EXT_REQUEST_N_I),
    .q_o(req_n_s)
  );

  rpsd_sync #(.W(1), .RST_VAL(1'b1)) u_done_sync (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .d_i(EXT_DONE_N_I),
    .q_o(done_n_s)
  );

  // ==========================================================
  // APB decode
  wire setup = PSEL_I & ~PENABLE_I;
  wire access = PSEL_I & PENABLE_I;
  wire wr = access & PWRITE_I;
  wire sel_ctrl = PADDR_I == OFF_CTRL;
  wire sel_status = PADDR_I == OFF_STATUS;
  wire sel_xcount = PADDR_I == OFF_XCOUNT;
  wire sel_xlen = PADDR_I == OFF_XLEN;
  logic [N_POOLS-1:0] sel_pool;
  logic [N_POOLS-1:0] pool_avail;
  logic [N_POOLS*LEN_W-1:0] pool_size;
  logic [APB_DW-1:0] pool_rd [N_POOLS+1];

  assign pool_rd[0] = '0;
  for (genvar k = 0; k < N_POOLS; k++) begin : g_pdec
    assign sel_pool[k] = PADDR_I == APB_AW'(OFF_POOL0 + APB_AW'(k) * OFF_POOL_STEP);
    assign pool_avail[k] = pool_q[k].avail;
    assign pool_size[k*LEN_W +: LEN_W] = pool_q[k].size;
    assign pool_rd[k+1] = pool_rd[k] | (sel_pool[k] ?
      ((APB_DW'(pool_q[k].avail) << POOL_AVAIL_BIT) | APB_DW'(pool_q[k].size)) : '0);
  end

  wire mapped = sel_ctrl | sel_status | sel_xcount | sel_xlen | (|sel_pool);
  wire ext_busy = state_q != ST_IDLE;
  wire [APB_DW-1:0] status_word = (APB_DW'(normal_completion_pending_q) << STAT_NORMAL_COMPLETION_PENDING_BIT)
    | (APB_DW'(buffer_not_ready_pending_q) << STAT_BUFFER_NOT_READY_PENDING_BIT)
    | (APB_DW'(pool_sel_q) << STAT_POOL_LSB)
    | (APB_DW'(ext_busy) << STAT_BUSY_BIT)
    | (APB_DW'(frame_pend_q) << STAT_PEND_BIT);
  wire [APB_DW-1:0] rd_word = sel_ctrl ? APB_DW'(ctrl_q) :
    sel_status ? status_word :
    sel_xcount ? APB_DW'(xcount_q) :
    sel_xlen ? APB_DW'(xlen_q) : pool_rd[N_POOLS];
  wire clr_normal_completion_pending = wr & sel_status & PWDATA_I[STAT_NORMAL_COMPLETION_PENDING_BIT];
  wire clr_buffer_not_ready_pending = wr & sel_status & PWDATA_I[STAT_BUFFER_NOT_READY_PENDING_BIT];

  // read data is caught in setup so the access phase answers at once
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= rd_word;
      pslverr_q <= ~mapped;
    end
  end

  assign PREADY_O = 1'b1;
  assign PRDATA_O = prdata_q;
  assign PSLVERR_O = pslverr_q & access;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_q <= CTRL_RST;
      xcount_q <= '0;
    end else begin
      if (wr & sel_ctrl) ctrl_q <= PWDATA_I[CTRL_W-1:0];
      if (wr & sel_xcount) xcount_q <= PWDATA_I[LEN_W-1:0];
    end
  end

  // ==========================================================
  // receive pool selection
  logic pick_hit;
  logic [POOL_IDX_W-1:0] pick_idx;

  rpsd_pool_pick #(.N(N_POOLS)) u_pick (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .en_i(ctrl_q.pool_en),
    .avail_i(pool_avail),
    .size_i(pool_size),
    .len_i(rx_len_q),
    .hit_o(pick_hit),
    .idx_o(pick_idx)
  );

  // a miss keeps the frame waiting; the fifo filling then raises the flag
  wire search = frame_pend_q & ~buffer_not_ready_pending_q & ctrl_q.eth_receive_dma_enable;
  wire grant_d = search & pick_hit;
  assign RX_READY_O = ~frame_pend_q;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      frame_pend_q <= 1'b0;
      rx_len_q <= '0;
      grant_q <= 1'b0;
      pool_sel_q <= '0;
    end else begin
      grant_q <= grant_d;
      if (grant_d) begin
        frame_pend_q <= 1'b0;
        pool_sel_q <= pick_idx;
      end else if (RX_FRAME_I & ~frame_pend_q) begin
        frame_pend_q <= 1'b1;
        rx_len_q <= RX_LEN_I;
      end
    end
  end

  for (genvar k = 0; k < N_POOLS; k++) begin : g_pool
    always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
        pool_q[k] <= POOL_RST;
      end else if (wr & sel_pool[k]) begin
        pool_q[k].avail <= PWDATA_I[POOL_AVAIL_BIT];
        pool_q[k].size <= PWDATA_I[LEN_W-1:0];
      end else if (grant_d && pick_idx == POOL_IDX_W'(k)) begin
        pool_q[k].avail <= 1'b0;
      end
    end
  end

  // set beats a same-cycle clear
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      buffer_not_ready_pending_q <= 1'b0;
    end else if (RX_FIFO_FULL_I) begin
      buffer_not_ready_pending_q <= 1'b1;
    end else if (clr_buffer_not_ready_pending) begin
      buffer_not_ready_pending_q <= 1'b0;
    end
  end

  assign RX_GRANT_O = grant_q;
  assign RX_POOL_O = pool_sel_q;

  // ==========================================================
  // external handshake
  logic [CHAN_W-1:0] chan_acc [N_EXT+1];
  assign chan_acc[0] = '0;
  for (genvar k = 0; k < N_EXT; k++) begin : g_chan
    assign chan_acc[k+1] = chan_acc[k] |
      (ctrl_q.ext_en[k] ? CHAN_W'(FIRST_EXT_CHAN + k) : '0);
  end

  // more than one enabled channel is not served at all
  wire ext_one = (ctrl_q.ext_en != '0) &&
    ((ctrl_q.ext_en & (ctrl_q.ext_en - N_EXT'(1))) == '0);
  wire chan_ok = ext_one & ctrl_q.req_src_ext;
  wire block_left = cnt_q != xcount_q;
  wire last_access = cnt_q == (xcount_q - LEN_W'(1));
  wire done_drive_d = ctrl_q.done_out & ctrl_q.last_flag & last_access;
  wire done_in_hit = ~ctrl_q.done_out & ~done_n_s;
  wire in_access = (state_q == ST_XFER) | (state_q == ST_WR) | (state_q == ST_GAP);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (chan_ok & ~req_n_s & block_left) state_d = ST_XFER;
      end
      ST_XFER: begin
        state_d = ctrl_q.mem_to_mem ? ST_WR : ST_GAP;
      end
      ST_WR: begin
        state_d = ST_GAP;
      end
      ST_GAP: begin
        // the wait outlasts the synchroniser, so a single pulse is not seen twice
        if (gap_q == GAP_CYCLES - 2'h1) begin
          state_d = (done_in_q | done_in_hit | ~block_left) ? ST_CLOSE : ST_IDLE;
        end
      end
      ST_CLOSE: begin
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  wire ack_d = (state_d == ST_XFER) | (state_d == ST_WR);
  wire rw_n_d = ctrl_q.dir_to_mem ? (state_d == ST_WR) : 1'b1;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_q <= ST_IDLE;
      gap_q <= '0;
      cnt_q <= '0;
      done_in_q <= 1'b0;
      ack_n_q <= 1'b1;
      rw_n_q <= 1'b1;
      done_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      gap_q <= (state_q == ST_GAP) ? gap_q + 2'h1 : '0;
      ack_n_q <= ~ack_d;
      rw_n_q <= rw_n_d;
      done_n_q <= ~(ack_d & done_drive_d);
      if (state_q == ST_CLOSE) begin
        cnt_q <= '0;
        done_in_q <= 1'b0;
      end else begin
        if (state_q == ST_GAP && gap_q == '0) cnt_q <= cnt_q + LEN_W'(1);
        if (in_access & done_in_hit) done_in_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // buffer close and completion flag
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      close_q <= 1'b0;
      xlen_q <= '0;
    end else begin
      close_q <= state_q == ST_CLOSE;
      if (state_q == ST_CLOSE) xlen_q <= LEN_W'(cnt_q * XFER_BYTES_P);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      normal_completion_pending_q <= 1'b0;
    end else if (state_q == ST_CLOSE) begin
      normal_completion_pending_q <= 1'b1;
    end else if (clr_normal_completion_pending) begin
      normal_completion_pending_q <= 1'b0;
    end
  end

  assign EXT_ACKNOWLEDGE_N_O = ack_n_q;
  assign MEM_CYCLE_O = ~ack_n_q;
  assign EXT_RW_N_O = rw_n_q;
  assign EXT_CHAN_O = chan_acc[N_EXT];
  assign EXT_DONE_N_O = done_n_q;
  assign EXT_DONE_OE_N_O = ~ctrl_q.done_out;
  assign DESC_CLOSE_O = close_q;
  assign DESC_LEN_O = xlen_q;

  // ==========================================================
  // checks
  property p_ack_mem;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      !EXT_ACKNOWLEDGE_N_O == MEM_CYCLE_O;
  endproperty
  a_ack_mem: assert property (p_ack_mem) else $error("ack and memory cycle differ");

  property p_full_flag;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      RX_FIFO_FULL_I |=> buffer_not_ready_pending_q ##1 buffer_not_ready_pending_q;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("fifo full not flagged");

  property p_halt;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      buffer_not_ready_pending_q |=> !RX_GRANT_O;
  endproperty
  a_halt: assert property (p_halt) else $error("grant while not ready");

  property p_grant_ok;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      RX_GRANT_O |-> ctrl_q.pool_en[RX_POOL_O] || $past(wr);
  endproperty
  a_grant_ok: assert property (p_grant_ok) else $error("grant from disabled pool");

  sequence s_read_part;
    !EXT_ACKNOWLEDGE_N_O && state_q == ST_XFER && ctrl_q.mem_to_mem;
  endsequence
  sequence s_write_part;
    !EXT_ACKNOWLEDGE_N_O && state_q == ST_WR ##1 EXT_ACKNOWLEDGE_N_O;
  endsequence
  property p_m2m_both;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      s_read_part |=> s_write_part;
  endproperty
  a_m2m_both: assert property (p_m2m_both) else $error("second portion not acked");

  property p_gap;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      $rose(EXT_ACKNOWLEDGE_N_O) |-> EXT_ACKNOWLEDGE_N_O [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("ack gap too short");

  property p_done_out;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      !EXT_DONE_N_O |-> !EXT_DONE_OE_N_O && !EXT_ACKNOWLEDGE_N_O && ctrl_q.last_flag;
  endproperty
  a_done_out: assert property (p_done_out) else $error("done driven out of place");

  property p_close_flag;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      DESC_CLOSE_O |-> normal_completion_pending_q && DESC_LEN_O == LEN_W'($past(cnt_q) * XFER_BYTES_P);
  endproperty
  a_close_flag: assert property (p_close_flag) else $error("close without flag");

  property p_one_chan;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (state_q == ST_IDLE && state_d == ST_XFER) |-> ext_one && ctrl_q.req_src_ext;
  endproperty
  a_one_chan: assert property (p_one_chan) else $error("start without one channel");
endmodule
`default_nettype wire

// ---- verification/rpsd_periph.sv ----
`timescale 1ns/1ps
`default_nettype none
module rpsd_periph import rpsd_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic pulsed_i,
  input wire logic [7:0] done_at_i,
  input wire logic ack_n_i,
  input wire logic rw_n_i,
  output logic req_n_o,
  output logic done_n_o,
  output logic drive_o
);
  logic [7:0] acks_q;
  logic [31:0] store_q;
  // ==========
  // request: held for the whole block, or one pulse per access
  always_ff @(posedge clk_i) begin
    if (rst_i || !go_i) begin
      req_n_o <= 1'b1;
      acks_q <= 8'h00;
    end else begin
      req_n_o <= pulsed_i ? !ack_n_i : 1'b0;
      if (!ack_n_i)
        acks_q <= acks_q + 8'h01;
    end
  end
  // ==========
  // storage: no data bus at the ports, so captures are only counted
  always_ff @(posedge clk_i) begin
    if (rst_i)
      store_q <= 32'h00000000;
    else if (!ack_n_i && rw_n_i)
      store_q <= store_q + 32'h00000001;
  end
  assign drive_o = !ack_n_i && !rw_n_i;
  // gated with acknowledge so it can never be seen outside an access
  assign done_n_o = !(done_at_i != 8'h00 && acks_q + 8'h01 == done_at_i && !ack_n_i);
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench import rpsd_pkg::*; ;
  localparam int XB = 4;
  localparam int LIMIT = 20000;
  logic clk, rst, psel, pen, pwr, frame, ffull, go, pulsed, pready, pslverr, rdy, grant;
  logic ack_n, rw_n, memc, dn_o, dn_oe_n, dclose, req_n, pdone_n, err, drv;
  logic [7:0] paddr, done_at;
  logic [31:0] pwdata, prdata, rd, x;
  logic [15:0] rlen, dlen, len_got, ln;
  logic [1:0] pool;
  logic [2:0] chan;
  logic [3:0] av;
  int mismatches, cmp_count, seed, cyc, acks, rwl, dnl, closes, got, exp, sz[4];
  rpsd_ctrl_s c;
  wire logic done_pin = (dn_oe_n === 1'b0) ? dn_o : pdone_n;
  rpsd_top #(.XFER_BYTES_P(XB)) i_rpsd_top (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_FRAME_I(frame), .RX_LEN_I(rlen),
    .RX_FIFO_FULL_I(ffull), .RX_READY_O(rdy), .RX_GRANT_O(grant), .RX_POOL_O(pool),
    .EXT_REQUEST_N_I(req_n), .EXT_ACKNOWLEDGE_N_O(ack_n), .EXT_RW_N_O(rw_n),
    .MEM_CYCLE_O(memc), .EXT_CHAN_O(chan), .EXT_DONE_N_I(done_pin), .EXT_DONE_N_O(dn_o),
    .EXT_DONE_OE_N_O(dn_oe_n), .DESC_CLOSE_O(dclose), .DESC_LEN_O(dlen));
  rpsd_periph i_rpsd_periph (.clk_i(clk), .rst_i(rst), .go_i(go), .pulsed_i(pulsed),
    .done_at_i(done_at), .ack_n_i(ack_n), .rw_n_i(rw_n), .req_n_o(req_n),
    .done_n_o(pdone_n), .drive_o(drv));
  // ==========
  // clock, timeout, monitor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      print_verdict();
    end
  end
  always @(posedge clk) begin
    if (!rst && closes == 0) begin
      if (memc !== !ack_n)
        chk(32'(memc), 32'(!ack_n));
      if (ack_n === 1'b0) begin
        acks++;
        rwl += (drv === 1'b1);
      end
      dnl += (dn_o === 1'b0 && dn_oe_n === 1'b0);
      if (dclose === 1'b1) begin
        closes++;
        len_got = dlen;
      end
    end
  end
  // ==========
  // shared tasks and the reference model
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic set_pool(input int i);
    apb(1'b1, 8'(OFF_POOL0 + OFF_POOL_STEP * i), {av[i], 15'h0000, 16'(sz[i])});
  endtask
  function automatic int pick(input logic [3:0] en, input logic [15:0] len);
    for (int i = 0; i < 4; i++) begin
      if (!en[i])
        return -1;
      if (av[i] && sz[i] >= len)
        return i;
    end
    return -1;
  endfunction
  task automatic wait_grant(input int lim);
    got = -1;
    for (int n = 0; n < lim && got < 0; n++) begin
      @(posedge clk);
      if (grant === 1'b1)
        got = pool;
    end
  endtask
  task automatic frame_go(input logic [15:0] len, input int lim);
    @(posedge clk);
    frame <= 1'b1;
    rlen <= len;
    @(posedge clk);
    frame <= 1'b0;
    wait_grant(lim);
  endtask
  task automatic ext(input int ch, m2m, dout, dir, src, two, xc, pl, da);
    int tr;
    c = '0;
    c.ext_en = 4'(1 << ch) | (two ? 4'(1 << ((ch + 1) % 4)) : 4'h0);
    c.mem_to_mem = 1'(m2m);
    c.done_out = 1'(dout);
    c.last_flag = 1'(dout);
    c.req_src_ext = 1'(src);
    c.dir_to_mem = 1'(dir);
    apb(1'b1, OFF_XCOUNT, 32'(xc));
    {acks, rwl, dnl, closes} = '0;
    pulsed <= 1'(pl);
    done_at <= 8'(da);
    apb(1'b1, OFF_CTRL, 32'(c));
    @(posedge clk);
    chk(32'(dn_oe_n), 32'(!dout));
    if (!two)
      chk(32'(chan), 32'(FIRST_EXT_CHAN + ch));
    go <= 1'b1;
    for (int n = 0; n < 90 && closes == 0; n++)
      @(posedge clk);
    go <= 1'b0;
    tr = (src && !two) ? ((da != 0 && da < xc) ? da : xc) : 0;
    chk(32'(acks), 32'(m2m ? 2 * tr : tr));
    chk(32'(rwl), 32'(dir ? tr : 0));
    chk(32'(dnl), 32'((dout && tr > 0) ? (m2m ? 2 : 1) : 0));
    chk(32'(closes), 32'(tr > 0));
    if (tr > 0)
      chk(32'(len_got), 32'(tr * XB));
    repeat (12) @(posedge clk);
    apb(1'b1, OFF_CTRL, 32'h00000000);
    apb(1'b0, OFF_STATUS, 32'h00000000);
    chk(32'(rd[STAT_NORMAL_COMPLETION_PENDING_BIT]), 32'(tr > 0));
    apb(1'b1, OFF_STATUS, 32'h1 << STAT_NORMAL_COMPLETION_PENDING_BIT);
    // a held request restarts the block after close; reset drops the leftover count
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    $display("ext test m2m=%0d done_out=%0d done_at=%0d ended", m2m, dout, da);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    {psel, pen, pwr, frame, ffull, go, pulsed} = '0;
    {paddr, done_at, pwdata, rlen} = '0;
    seed = 71607;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'({ack_n, rw_n, memc, dn_oe_n, rdy, dclose}), 32'h36);
    apb(1'b0, OFF_CTRL, 32'h00000000);
    chk(rd, 32'(CTRL_RST));
    apb(1'b0, 8'h40, 32'h00000000);
    chk(32'(err), 32'h1);
    chk(rd, 32'h00000000);
    x = 32'($random(seed)) & 32'((1 << CTRL_W) - 1);
    apb(1'b1, OFF_CTRL, x);
    apb(1'b0, OFF_CTRL, 32'h00000000);
    chk(rd, x);
    $display("register test ended");
    // pool search: fixed depth first, then random enable holes
    for (int t = 0; t < 16; t++) begin
      c = '0;
      c.eth_receive_dma_enable = 1'b1;
      c.pool_en = (t < 4) ? 4'(4'hF >> t) : 4'($random(seed));
      apb(1'b1, OFF_CTRL, 32'(c));
      for (int i = 0; i < 4; i++) begin
        av[i] = 1'($random(seed));
        sz[i] = $random(seed) & 16'h0FFF;
        set_pool(i);
      end
      ln = t[0] ? 16'(sz[1]) : 16'($random(seed) & 16'h0FFF);
      exp = pick(c.pool_en, ln);
      frame_go(ln, 10);
      chk(32'(got), 32'(exp));
      if (exp < 0) begin
        // search held off while the pools change, so no grant slips by unseen
        c.pool_en = 4'hF;
        c.eth_receive_dma_enable = 1'b0;
        apb(1'b1, OFF_CTRL, 32'(c));
        av[3] = 1'b1;
        sz[3] = 16'hFFFF;
        set_pool(3);
        c.eth_receive_dma_enable = 1'b1;
        apb(1'b1, OFF_CTRL, 32'(c));
        exp = pick(4'hF, ln);
        wait_grant(12);
        chk(32'(got), 32'(exp));
      end
    end
    $display("pool search test ended");
    @(posedge clk);
    ffull <= 1'b1;
    @(posedge clk);
    ffull <= 1'b0;
    apb(1'b0, OFF_STATUS, 32'h00000000);
    chk(32'(rd[STAT_BUFFER_NOT_READY_PENDING_BIT]), 32'h1);
    av[0] = 1'b1;
    sz[0] = 16'hFFFF;
    set_pool(0);
    frame_go(16'h0040, 10);
    chk(32'(got), 32'hFFFFFFFF);
    c.pool_en = 4'hF;
    c.eth_receive_dma_enable = 1'b0;
    apb(1'b1, OFF_CTRL, 32'(c));
    apb(1'b1, OFF_CTRL, 32'h00000000);
    set_pool(0);
    c.eth_receive_dma_enable = 1'b1;
    apb(1'b1, OFF_CTRL, 32'(c));
    apb(1'b1, OFF_STATUS, 32'h1 << STAT_BUFFER_NOT_READY_PENDING_BIT);
    wait_grant(12);
    chk(32'(got), 32'h0);
    $display("not ready test ended");
    apb(1'b1, OFF_CTRL, 32'h00000000);
    for (int ch = 0; ch < 4; ch++)
      ext(ch, 0, 0, 1, 1, 0, 3, 0, 0);
    ext($random(seed) & 3, 0, 0, 1, 1, 0, 3, 1, 0);
    ext($random(seed) & 3, 1, 1, 1, 1, 0, 2, 0, 0);
    ext($random(seed) & 3, 0, 1, 0, 1, 0, 2, 0, 0);
    ext($random(seed) & 3, 0, 0, 1, 1, 0, 8, 0, 2);
    ext($random(seed) & 3, 0, 0, 1, 0, 0, 3, 0, 0);
    ext($random(seed) & 3, 0, 0, 1, 1, 1, 3, 0, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
